// file: src/pm_io_port.sv
// one 8-bit port: latch or alternate function onto the pins
`timescale 1ns/1ns
module pm_io_port #(
	parameter int W = 8,
	parameter bit OPEN_DRAIN = 1'b0
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// port state
	input wire logic [W-1:0] latch_i,
	input wire logic [W-1:0] dir_i,
	// alternate function
	input wire logic [W-1:0] alt_en_i,
	input wire logic [W-1:0] alt_val_i,
	input wire logic [W-1:0] alt_drv_i,
	// pins
	output logic [W-1:0] pin_o,
	output logic [W-1:0] pin_oe_b_o
);
	logic [W-1:0] val;
	logic [W-1:0] drv;

	assign val = (alt_en_i & alt_val_i) | (~alt_en_i & latch_i);
	assign drv = (alt_en_i & alt_drv_i) | (~alt_en_i & dir_i);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			pin_o <= '0;
			pin_oe_b_o <= '1;
		end else if (OPEN_DRAIN) begin
			pin_o <= '0;
			pin_oe_b_o <= ~(drv & ~val);
		end else begin
			pin_o <= val;
			pin_oe_b_o <= ~drv;
		end
	end

	a_port_release: assert property (@(posedge clk_sys_i)
		!rst_b_i |=> pin_oe_b_o == '1)
		else $error("port drives right after reset");
	a_port_drive: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		1 |=> (pin_oe_b_o == ~($past(drv) &
		(OPEN_DRAIN ? ~$past(val) : '1))))
		else $error("port drive enable wrong");
endmodule

// file: src/pm_irq_edge.sv
// both-edge detect and ordering of the external interrupt pins
`timescale 1ns/1ns
module pm_irq_edge (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// pins, bit 0 is ext_irq_1
	input wire logic [2:0] irq_pin_i,
	// results
	output logic [2:0] edge_o,
	output logic [1:0] top_o
);
	logic [2:0] prev_reg;
	logic armed_reg;
	logic [2:0] hit;

	// first sample after reset only arms, so no false edge
	assign hit = armed_reg ? (irq_pin_i ^ prev_reg) : 3'h0;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			prev_reg <= 3'h0;
			armed_reg <= 1'b0;
			edge_o <= 3'h0;
			top_o <= 2'h0;
		end else begin
			prev_reg <= irq_pin_i;
			armed_reg <= 1'b1;
			edge_o <= hit;
			if (hit[0])
				top_o <= 2'h1;
			else if (hit[1])
				top_o <= 2'h2;
			else if (hit[2])
				top_o <= 2'h3;
			else
				top_o <= 2'h0;
		end
	end

	a_irq_order: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		edge_o[0] |-> top_o == 2'h1)
		else $error("ext_irq_1 not ranked first");
endmodule

// file: src/pm_pin_mux.sv
// top of the port and pin-function multiplexer
// ==========================================
// Summary of operation
// - port a: eight pins, own direction bits
// - reset leaves every port a pin input
// - port a output drives high and low
// - port b open drain: one leaves undriven
// - port c like a, plus key wake
// - port d bits 7..4 carry serial signals
// - d3 timer4 half, d2 irq, d1/0 subclock
// - segment input port, pairs become segments
// - port f bits 0..3 feed irq/timers/trigger
// - port f bits 4..7 carry pwm outputs
// - commons 2,3 idle half; 3 at third
// - segments 16..23 analog, pairs then quad
// - ext_irq_1 ranks highest of external pins
`timescale 1ns/1ns
module pm_pin_mux #(
	parameter bit KEY_WAKE = 1'b1
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// general ports
	input wire logic [7:0] cmos_a_i,
	output logic [7:0] cmos_a_o,
	output logic [7:0] cmos_a_oe_b_o,
	input wire logic [7:0] drain_b_i,
	output logic [7:0] drain_b_o,
	output logic [7:0] drain_b_oe_b_o,
	input wire logic [7:0] wake_c_i,
	output logic [7:0] wake_c_o,
	output logic [7:0] wake_c_oe_b_o,
	input wire logic [7:0] shared_d_i,
	output logic [7:0] shared_d_o,
	output logic [7:0] shared_d_oe_b_o,
	input wire logic [7:0] shared_f_i,
	output logic [7:0] shared_f_o,
	output logic [7:0] shared_f_oe_b_o,
	// segment input port
	input wire logic [3:0] segp_i,
	input wire logic [3:0] segp_data_i,
	output logic [3:0] segp_o,
	output logic [3:0] segp_oe_b_o,
	// display commons and analog segments
	input wire logic [1:0] lcd_unused_i,
	input wire logic [3:0] com_data_i,
	output logic [3:0] com_o,
	output logic [3:0] com_oe_b_o,
	input wire logic [7:0] aseg_data_i,
	output logic [7:0] aseg_o,
	output logic [7:0] aseg_oe_b_o,
	output logic [7:0] analog_sel_o,
	// serial unit
	input wire logic serial_ready_b_i,
	input wire logic serial_clk_i,
	input wire logic serial_clk_drive_i,
	input wire logic serial_out_i,
	output logic serial_in_o,
	output logic serial_clk_o,
	// timers, converter, sub-clock, pwm
	input wire logic tmr4_ovf_i,
	input wire logic subclock_out_i,
	input wire logic [3:0] pwm_i,
	output logic subclock_in_o,
	output logic tmr3_cnt_o,
	output logic tmr5_cnt_o,
	output logic adc_trig_o,
	// external interrupts and wake
	input wire logic ext_irq_1_i,
	output logic [2:0] ext_irq_edge_o,
	output logic [1:0] ext_irq_top_o,
	output logic key_wake_o
);
	logic [7:0] data_a_reg, dir_a_reg, data_b_reg, dir_b_reg;
	logic [7:0] data_c_reg, dir_c_reg, data_d_reg, dir_d_reg;
	logic [7:0] data_f_reg, dir_f_reg;
	logic [3:0] func_reg;
	logic [1:0] segp_grp_reg;
	logic [1:0] duty_reg;
	logic [2:0] ana_reg;
	logic t4_half_reg;
	logic [7:0] rdata_next;
	logic [7:0] alt_en_d, alt_val_d, alt_drv_d;
	logic [7:0] alt_en_f;
	logic [7:0] ana_pin;
	logic [3:0] com_used;
	logic ser_on;

	// input bits show the pin, output bits the latch
	function automatic logic [7:0] port_rd(input logic [7:0] l,
		input logic [7:0] d, input logic [7:0] p);
		port_rd = (l & d) | (p & ~d);
	endfunction

	// ==========================================
	// register writes
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			data_a_reg <= pm_pkg::RST_BYTE;
			dir_a_reg <= pm_pkg::RST_BYTE;
			data_b_reg <= pm_pkg::RST_BYTE;
			dir_b_reg <= pm_pkg::RST_BYTE;
			data_c_reg <= pm_pkg::RST_BYTE;
			dir_c_reg <= pm_pkg::RST_BYTE;
			data_d_reg <= pm_pkg::RST_BYTE;
			dir_d_reg <= pm_pkg::RST_BYTE;
			data_f_reg <= pm_pkg::RST_BYTE;
			dir_f_reg <= pm_pkg::RST_BYTE;
			func_reg <= 4'h0;
			segp_grp_reg <= 2'h0;
			duty_reg <= pm_pkg::DUTY_QUARTER;
			ana_reg <= 3'h0;
		end else if (wr_i) begin
			unique case (addr_i)
				pm_pkg::ADR_A_DATA: data_a_reg <= wdata_i;
				pm_pkg::ADR_A_DIR: dir_a_reg <= wdata_i;
				pm_pkg::ADR_B_DATA: data_b_reg <= wdata_i;
				pm_pkg::ADR_B_DIR: dir_b_reg <= wdata_i;
				pm_pkg::ADR_C_DATA: data_c_reg <= wdata_i;
				pm_pkg::ADR_C_DIR: dir_c_reg <= wdata_i;
				pm_pkg::ADR_D_DATA: data_d_reg <= wdata_i;
				pm_pkg::ADR_D_DIR: dir_d_reg <= wdata_i;
				pm_pkg::ADR_F_DATA: data_f_reg <= wdata_i;
				pm_pkg::ADR_F_DIR: dir_f_reg <= wdata_i;
				pm_pkg::ADR_SEGP: segp_grp_reg <=
					wdata_i[pm_pkg::SEGP_GRP_LSB +: 2];
				pm_pkg::ADR_FUNC: func_reg <= wdata_i[3:0];
				pm_pkg::ADR_LCD: begin
					duty_reg <= wdata_i[pm_pkg::LCD_DUTY_LSB +: 2];
					ana_reg <= wdata_i[pm_pkg::LCD_ANA_LSB +: 3];
				end
				default: ;
			endcase
		end
	end

	// ==========================================
	// register reads, data valid the next cycle only
	always_comb begin
		rdata_next = 8'h00;
		unique case (addr_i)
			pm_pkg::ADR_A_DATA:
				rdata_next = port_rd(data_a_reg, dir_a_reg, cmos_a_i);
			pm_pkg::ADR_A_DIR: rdata_next = dir_a_reg;
			pm_pkg::ADR_B_DATA:
				rdata_next = port_rd(data_b_reg, dir_b_reg, drain_b_i);
			pm_pkg::ADR_B_DIR: rdata_next = dir_b_reg;
			pm_pkg::ADR_C_DATA:
				rdata_next = port_rd(data_c_reg, dir_c_reg, wake_c_i);
			pm_pkg::ADR_C_DIR: rdata_next = dir_c_reg;
			pm_pkg::ADR_D_DATA:
				rdata_next = port_rd(data_d_reg, dir_d_reg, shared_d_i);
			pm_pkg::ADR_D_DIR: rdata_next = dir_d_reg;
			pm_pkg::ADR_F_DATA:
				rdata_next = port_rd(data_f_reg, dir_f_reg, shared_f_i);
			pm_pkg::ADR_F_DIR: rdata_next = dir_f_reg;
			pm_pkg::ADR_SEGP:
				rdata_next = {2'h0, segp_grp_reg, segp_i};
			pm_pkg::ADR_FUNC: rdata_next = {4'h0, func_reg};
			pm_pkg::ADR_LCD: rdata_next = {3'h0, ana_reg, duty_reg};
			pm_pkg::ADR_STAT: rdata_next =
				{3'h0, key_wake_o, t4_half_reg, shared_f_i[0],
				shared_d_i[2], ext_irq_1_i};
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i)
			rdata_o <= 8'h00;
		else
			rdata_o <= rd_i ? rdata_next : 8'h00;
	end

	// ==========================================
	// alternate functions of ports d and f
	assign ser_on = func_reg[pm_pkg::FN_SER];
	assign alt_en_d = {{4{ser_on}}, func_reg[pm_pkg::FN_T4], 1'b0,
		{2{func_reg[pm_pkg::FN_SUB]}}};
	assign alt_val_d = {serial_ready_b_i, serial_clk_i, serial_out_i,
		1'b1, t4_half_reg, 1'b1, 1'b1, subclock_out_i};
	// serial in and sub-clock in are released, never driven
	assign alt_drv_d = {1'b1, serial_clk_drive_i, 1'b1, 1'b0,
		1'b1, 1'b0, 1'b0, 1'b1};
	assign alt_en_f = {{4{func_reg[pm_pkg::FN_PWM]}}, 4'h0};

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i)
			t4_half_reg <= 1'b0;
		else if (tmr4_ovf_i)
			t4_half_reg <= ~t4_half_reg;
	end

	// pins used as inputs by other units, taken in all modes
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			serial_in_o <= 1'b0;
			serial_clk_o <= 1'b0;
			subclock_in_o <= 1'b0;
			tmr3_cnt_o <= 1'b0;
			tmr5_cnt_o <= 1'b0;
			adc_trig_o <= 1'b0;
			key_wake_o <= 1'b0;
		end else begin
			serial_in_o <= shared_d_i[4];
			serial_clk_o <= shared_d_i[6];
			subclock_in_o <= shared_d_i[1];
			tmr3_cnt_o <= shared_f_i[1];
			tmr5_cnt_o <= shared_f_i[2];
			adc_trig_o <= shared_f_i[3];
			key_wake_o <= KEY_WAKE && |(~wake_c_i & ~dir_c_reg);
		end
	end

	// ==========================================
	// port drivers
	pm_io_port #(.OPEN_DRAIN(1'b0)) u_port_a (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.latch_i(data_a_reg), .dir_i(dir_a_reg),
		.alt_en_i(8'h00), .alt_val_i(8'h00), .alt_drv_i(8'h00),
		.pin_o(cmos_a_o), .pin_oe_b_o(cmos_a_oe_b_o));
	pm_io_port #(.OPEN_DRAIN(1'b1)) u_port_b (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.latch_i(data_b_reg), .dir_i(dir_b_reg),
		.alt_en_i(8'h00), .alt_val_i(8'h00), .alt_drv_i(8'h00),
		.pin_o(drain_b_o), .pin_oe_b_o(drain_b_oe_b_o));
	pm_io_port #(.OPEN_DRAIN(1'b0)) u_port_c (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.latch_i(data_c_reg), .dir_i(dir_c_reg),
		.alt_en_i(8'h00), .alt_val_i(8'h00), .alt_drv_i(8'h00),
		.pin_o(wake_c_o), .pin_oe_b_o(wake_c_oe_b_o));
	pm_io_port #(.OPEN_DRAIN(1'b1)) u_port_d (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.latch_i(data_d_reg), .dir_i(dir_d_reg),
		.alt_en_i(alt_en_d), .alt_val_i(alt_val_d),
		.alt_drv_i(alt_drv_d),
		.pin_o(shared_d_o), .pin_oe_b_o(shared_d_oe_b_o));
	pm_io_port #(.OPEN_DRAIN(1'b1)) u_port_f (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.latch_i(data_f_reg), .dir_i(dir_f_reg),
		.alt_en_i(alt_en_f), .alt_val_i({pwm_i, 4'h0}),
		.alt_drv_i(8'hf0),
		.pin_o(shared_f_o), .pin_oe_b_o(shared_f_oe_b_o));

	pm_irq_edge u_irq (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.irq_pin_i({shared_f_i[0], shared_d_i[2], ext_irq_1_i}),
		.edge_o(ext_irq_edge_o), .top_o(ext_irq_top_o));

	// ==========================================
	// display pins
	assign com_used = (duty_reg == pm_pkg::DUTY_HALF) ? 4'h3 :
		(duty_reg == pm_pkg::DUTY_THIRD) ? 4'h7 : 4'hf;

	generate
		for (genvar k = 0; k < 8; k++) begin : g_ana
			// seg16..19 switch in pairs, seg20..23 as one quad
			assign ana_pin[k] = ana_reg[(k < 4) ? k / 2 : 2];
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			segp_o <= 4'h0;
			segp_oe_b_o <= 4'hf;
			com_o <= 4'h0;
			com_oe_b_o <= 4'hf;
			aseg_o <= 8'h00;
			aseg_oe_b_o <= 8'hff;
			analog_sel_o <= 8'h00;
		end else begin
			segp_o <= segp_data_i;
			segp_oe_b_o <= ~{{2{segp_grp_reg[1]}},
				{2{segp_grp_reg[0]}}};
			com_o <= com_data_i & com_used;
			com_oe_b_o <= ~com_used;
			aseg_o <= aseg_data_i & ~ana_pin;
			aseg_oe_b_o <= ana_pin;
			analog_sel_o <= {<<{ana_pin}};
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	a_dir_a_follows: assert property (
		wr_i && addr_i == pm_pkg::ADR_A_DIR |=> ##1
		cmos_a_oe_b_o == ~$past(wdata_i, 2))
		else $error("port a direction not applied");
	a_cmos_level: assert property (
		1 |=> ((cmos_a_o ^ $past(data_a_reg)) &
		~cmos_a_oe_b_o) == 8'h00)
		else $error("port a driven level wrong");
	a_key_wake_src: assert property (
		dir_c_reg == 8'h00 && wake_c_i != 8'hFF |=>
		key_wake_o == KEY_WAKE)
		else $error("key wake without option");
	a_serial_out_pin: assert property (
		ser_on && dir_d_reg[5] |=>
		shared_d_oe_b_o[5] == $past(serial_out_i))
		else $error("serial out not on port d bit 5");
	a_t4_half_toggle: assert property (
		tmr4_ovf_i |=> t4_half_reg != $past(t4_half_reg))
		else $error("timer4 half output did not toggle");
	a_seg_pairs: assert property (
		1 |=> segp_oe_b_o[1] == segp_oe_b_o[0] &&
		segp_oe_b_o[3] == segp_oe_b_o[2])
		else $error("segment port pair split");
	a_pwm_pins: assert property (
		func_reg[pm_pkg::FN_PWM] |=>
		shared_f_oe_b_o[7:4] == ~$past(~pwm_i))
		else $error("pwm not on port f");
	a_com_duty: assert property (
		duty_reg == pm_pkg::DUTY_HALF |=>
		com_oe_b_o[3:2] == 2'h3 && com_o[3:2] == 2'h0)
		else $error("unused common driven at half duty");
	a_ana_quad: assert property (
		1 |=> aseg_oe_b_o[7:4] == {4{aseg_oe_b_o[4]}})
		else $error("analog quad split");
	a_latch_kept: assert property (
		!wr_i |=> $stable(data_d_reg) && $stable(data_f_reg))
		else $error("latch changed without a write");

	c_serial_on: cover property (wr_i && addr_i == pm_pkg::ADR_FUNC
		&& wdata_i[pm_pkg::FN_SER]);
	c_pwm_out: cover property (func_reg[pm_pkg::FN_PWM] && |pwm_i);
	c_irq_edge: cover property (ext_irq_edge_o[0]);
	c_key_wake: cover property (key_wake_o);
endmodule

// file: src/pm_pkg.sv
// constants for the port and pin-function multiplexer
package pm_pkg;
	// ==========================================
	// register bus
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] ADR_A_DATA = 4'h0;
	localparam logic [3:0] ADR_A_DIR = 4'h1;
	localparam logic [3:0] ADR_B_DATA = 4'h2;
	localparam logic [3:0] ADR_B_DIR = 4'h3;
	localparam logic [3:0] ADR_C_DATA = 4'h4;
	localparam logic [3:0] ADR_C_DIR = 4'h5;
	localparam logic [3:0] ADR_D_DATA = 4'h6;
	localparam logic [3:0] ADR_D_DIR = 4'h7;
	localparam logic [3:0] ADR_F_DATA = 4'h8;
	localparam logic [3:0] ADR_F_DIR = 4'h9;
	localparam logic [3:0] ADR_SEGP = 4'hA;
	localparam logic [3:0] ADR_FUNC = 4'hB;
	localparam logic [3:0] ADR_LCD = 4'hC;
	localparam logic [3:0] ADR_STAT = 4'hD;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ==========================================
	// field positions
	localparam int FN_SER = 0;
	localparam int FN_T4 = 1;
	localparam int FN_SUB = 2;
	localparam int FN_PWM = 3;
	localparam int LCD_DUTY_LSB = 0;
	localparam int LCD_ANA_LSB = 2;
	localparam int SEGP_GRP_LSB = 4;
	localparam logic [1:0] DUTY_HALF = 2'h0;
	localparam logic [1:0] DUTY_THIRD = 2'h1;
	localparam logic [1:0] DUTY_QUARTER = 2'h2;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_LOW_MIN_US = 16;
	localparam int RST_LOW_MIN_CYC =
		(RST_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: tb/pm_board.sv
// board circuitry model: external drivers on the port pins
`timescale 1ns/1ns
module pm_board #(
	parameter int W = 8
) (
	// device side
	input wire logic [W-1:0] o_i,
	input wire logic [W-1:0] oe_b_i,
	// board drivers
	input wire logic [W-1:0] ext_i,
	// resolved level
	output logic [W-1:0] pin_o
);
	// board drives every pin the device releases, so no level floats
	assign pin_o = (oe_b_i & ext_i) | (~oe_b_i & o_i);
endmodule

// file: tb/testbench.sv
// self-checking bench for the port and pin-function multiplexer
`timescale 1ns/1ns
module testbench;
	typedef struct {logic [7:0] v; logic [7:0] m; int s;} pm_exp_s;
	localparam logic [2:0][7:0] AOE = {8'hF0, 8'h0C, 8'h03};
	localparam logic [2:0][7:0] ASEL = {8'h0F, 8'h30, 8'hC0};
	localparam logic [2:0][2:0] TGL = {3'b100, 3'b110, 3'b011};
	// ==========================================
	// stimulus and observed nets
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	wire logic [5:0][7:0] po;
	wire logic [5:0][7:0] poe;
	wire logic [5:0][7:0] pin;
	logic [5:0][7:0] ext_val = '1;
	logic [3:0] segp_data = 4'hA;
	logic [3:0] com_data = 4'h9;
	logic [3:0] com_o;
	logic [3:0] com_oe_b;
	logic [7:0] asel;
	logic [7:0] aseg;
	logic [7:0] aseg_oe_b;
	logic sr_b = 1'b1;
	logic s_clk = 1'b1;
	logic s_drv = 1'b0;
	logic s_out = 1'b1;
	logic tmr4 = 1'b0;
	logic sub_out = 1'b0;
	logic [3:0] pwm = 4'h0;
	logic irq1 = 1'b0;
	wire logic [7:0] misc;
	logic [2:0] irq_edge;
	logic [1:0] irq_top;
	logic chk_go = 1'b0;
	logic irq_watch = 1'b0;
	pm_exp_s exp_q[$];
	pm_exp_s e;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int seed = 60982;

	always #5 clk_sys_i = ~clk_sys_i;
	assign po[5][7:4] = 4'h0;
	assign poe[5][7:4] = 4'hF;

	pm_pin_mux #(.KEY_WAKE(1'b1)) pm_pin_mux_i (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o),
		.cmos_a_i(pin[0]), .cmos_a_o(po[0]), .cmos_a_oe_b_o(poe[0]),
		.drain_b_i(pin[1]), .drain_b_o(po[1]), .drain_b_oe_b_o(poe[1]),
		.wake_c_i(pin[2]), .wake_c_o(po[2]), .wake_c_oe_b_o(poe[2]),
		.shared_d_i(pin[3]), .shared_d_o(po[3]), .shared_d_oe_b_o(poe[3]),
		.shared_f_i(pin[4]), .shared_f_o(po[4]), .shared_f_oe_b_o(poe[4]),
		.segp_i(pin[5][3:0]), .segp_data_i(segp_data),
		.segp_o(po[5][3:0]), .segp_oe_b_o(poe[5][3:0]),
		.lcd_unused_i(2'h0), .com_data_i(com_data), .com_o(com_o),
		.com_oe_b_o(com_oe_b), .aseg_data_i(8'h5A), .aseg_o(aseg),
		.aseg_oe_b_o(aseg_oe_b), .analog_sel_o(asel),
		.serial_ready_b_i(sr_b), .serial_clk_i(s_clk),
		.serial_clk_drive_i(s_drv), .serial_out_i(s_out),
		.serial_in_o(misc[7]), .serial_clk_o(misc[6]),
		.tmr4_ovf_i(tmr4), .subclock_out_i(sub_out), .pwm_i(pwm),
		.subclock_in_o(misc[5]), .tmr3_cnt_o(misc[4]),
		.tmr5_cnt_o(misc[3]), .adc_trig_o(misc[2]),
		.ext_irq_1_i(irq1), .ext_irq_edge_o(irq_edge),
		.ext_irq_top_o(irq_top), .key_wake_o(misc[1])
	);
	assign misc[0] = 1'b0;

	for (genvar k = 0; k < 6; k++) begin : g_brd
		pm_board #(.W(8)) pm_board_i (
			.o_i(po[k]), .oe_b_i(poe[k]), .ext_i(ext_val[k]), .pin_o(pin[k])
		);
	end

	// ==========================================
	// result watcher
	function automatic logic [7:0] actual(input int s);
		if (s >= 1 && s <= 6)
			return poe[s-1];
		if (s >= 7 && s <= 12)
			return po[s-7];
		case (s)
			0: return rdata_o;
			13: return misc;
			14: return {com_oe_b, com_o};
			15: return asel;
			16: return aseg_oe_b;
			17: return {3'h0, irq_edge, irq_top};
			18: return aseg;
			default: return 8'h55;
		endcase
	endfunction

	always @(negedge clk_sys_i) begin
		if (chk_go || (irq_watch && irq_edge !== 3'h0)) begin
			// an unexpected result meets a note that cannot match
			if (exp_q.size() == 0)
				e = '{8'hAA, 8'hFF, 99};
			else
				e = exp_q.pop_front();
			check_count++;
			if ((actual(e.s) & e.m) !== (e.v & e.m)) begin
				err_count++;
				$display("[FAIL] %0t exp %h got %h", $time, e.v & e.m,
					actual(e.s) & e.m);
			end
		end
	end

	// ==========================================
	// bus and check tasks
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask

	task automatic want(input int s, input logic [7:0] v, input logic [7:0] m);
		@(posedge clk_sys_i);
		exp_q.push_back('{v, m, s});
		chk_go <= 1'b1;
		@(posedge clk_sys_i);
		chk_go <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] v,
		input logic [7:0] m);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		exp_q.push_back('{v, m, 0});
		chk_go <= 1'b1;
		@(posedge clk_sys_i);
		chk_go <= 1'b0;
	endtask

	task automatic reset_chk(input int n);
		rst_b_i <= 1'b0;
		repeat (n) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		for (int p = 1; p <= 5; p++)
			want(p, 8'hFF, 8'hFF);
		rd_chk(pm_pkg::ADR_A_DIR, 8'h00, 8'hFF);
	endtask

	task automatic tally_and_finish;
		if (exp_q.size() != 0)
			err_count++;
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ==========================================
	// scenarios
	initial begin
		logic [7:0] lat;
		logic [7:0] dir;
		bit od;
		reset_chk(16);
		for (int p = 0; p < 5; p++) begin
			od = (p == 1 || p >= 3);
			repeat (3) begin
				lat = 8'($random(seed));
				dir = 8'($random(seed));
				ext_val[p] <= 8'($random(seed));
				wr(4'(2 * p), lat);
				wr(4'(2 * p + 1), dir);
				want(p + 1, od ? (~dir | lat) : ~dir, 8'hFF);
				want(p + 7, od ? 8'h00 : lat, od ? 8'hFF : dir);
				rd_chk(4'(2 * p), (dir & lat) | (~dir & ext_val[p]), 8'hFF);
			end
		end
		// key wake follows any low input pin of port c
		wr(pm_pkg::ADR_C_DIR, 8'h00);
		ext_val[2] <= 8'hF7;
		repeat (3) @(posedge clk_sys_i);
		want(13, 8'h02, 8'h02);
		ext_val[2] <= 8'hFF;
		repeat (3) @(posedge clk_sys_i);
		want(13, 8'h00, 8'h02);
		// serial, timer half and sub-clock on port d
		ext_val[3] <= 8'hFF;
		sr_b <= 1'b0;
		s_drv <= 1'b1;
		s_clk <= 1'b0;
		s_out <= 1'b0;
		wr(pm_pkg::ADR_D_DATA, 8'hFF);
		wr(pm_pkg::ADR_D_DIR, 8'hFF);
		wr(pm_pkg::ADR_FUNC, 8'h07);
		want(4, 8'h16, 8'hFF);
		want(13, 8'hA0, 8'hE0);
		@(posedge clk_sys_i);
		tmr4 <= 1'b1;
		@(posedge clk_sys_i);
		tmr4 <= 1'b0;
		want(4, 8'h1E, 8'hFF);
		rd_chk(pm_pkg::ADR_D_DATA, 8'hFF, 8'hFF);
		// pwm and count inputs on port f
		pwm <= 4'h5;
		ext_val[4] <= 8'hF5;
		wr(pm_pkg::ADR_F_DATA, 8'hFF);
		wr(pm_pkg::ADR_F_DIR, 8'hFF);
		wr(pm_pkg::ADR_FUNC, 8'h08);
		want(5, 8'h5F, 8'hFF);
		want(13, 8'h08, 8'h1C);
		for (int g = 0; g < 2; g++) begin
			wr(pm_pkg::ADR_SEGP, 8'h10 << g);
			want(6, ~(8'h03 << (2 * g)), 8'hFF);
			want(12, 8'hAA, 8'h03 << (2 * g));
		end
		rd_chk(pm_pkg::ADR_SEGP, {4'h2, segp_data[3:2], ext_val[5][1:0]},
			8'h3F);
		for (int d = 0; d < 4; d++) begin
			lat = (d == 0) ? 8'hC0 : (d == 1) ? 8'h80 : 8'h00;
			wr(pm_pkg::ADR_LCD, 8'(d));
			want(14, lat | (8'h09 & ~(lat >> 4)), 8'hFF);
		end
		for (int g = 0; g < 3; g++) begin
			wr(pm_pkg::ADR_LCD, 8'h02 | (8'h04 << g));
			want(16, AOE[g], 8'hFF);
			want(15, ASEL[g], 8'hFF);
			want(18, 8'h5A & ~AOE[g], 8'hFF);
		end
		// edges on all three interrupt pins, some at once
		wr(pm_pkg::ADR_FUNC, 8'h00);
		wr(pm_pkg::ADR_D_DIR, 8'h00);
		wr(pm_pkg::ADR_F_DIR, 8'h00);
		repeat (4) @(posedge clk_sys_i);
		irq_watch <= 1'b1;
		for (int g = 0; g < 3; g++) begin
			exp_q.push_back('{{3'h0, TGL[g], 2'(g + 1)}, 8'hFF, 17});
			@(posedge clk_sys_i);
			irq1 <= irq1 ^ TGL[g][0];
			ext_val[3][2] <= ext_val[3][2] ^ TGL[g][1];
			ext_val[4][0] <= ext_val[4][0] ^ TGL[g][2];
			repeat (8) @(posedge clk_sys_i);
		end
		irq_watch <= 1'b0;
		// a long mid-run reset must release every pin of ports a to f again
		wr(pm_pkg::ADR_A_DIR, 8'hFF);
		reset_chk(1601);
		tally_and_finish();
	end
endmodule
